// ---- logic/hpgrb_bank.sv ----
// Serial slave and control registers of a stereo headphone amplifier.
// Assumes a standard-mode bus master and a 10 MHz clock well above the bus rate.
`timescale 1ns/1ns
`default_nettype none
`include "hpgrb_defines.svh"

module hpgrb_bank #(
  parameter logic [6:0] DEV_ADDR = `HPGRB_DEV_ADDR,
  parameter logic [3:0] REVISION = `HPGRB_REV_CODE  // Value is arbitrary.
) (
  input  wire logic       CLK_IN,
  input  wire logic       SRST_IN,
  input  wire logic       SCL_IN,
  input  wire logic       SDA_IN,
  output var  logic       SDA_OUT,
  output var  logic       SDA_OE_OUT,
  output var  logic       LEFT_SILENCE_OUT,
  output var  logic       RIGHT_SILENCE_OUT,
  output var  logic [5:0] GAIN_CODE_OUT,
  output var  logic       LEFT_OUTPUT_FLOAT_OUT,
  output var  logic       RIGHT_OUTPUT_FLOAT_OUT
);

  // Reserved bus addresses cannot be served by this slave.
  if (DEV_ADDR[6:3] == 4'h0 || DEV_ADDR[6:3] == 4'hf) begin : g_bad_addr
    $error("Device address lies in a reserved bus address group.");
  end

  localparam hpgrb_pkg::hpgrb_bank_st_t BANK_RST = '{
    st:       hpgrb_pkg::HPGRB_IDLE,
    bitcnt:   4'h0,
    shreg:    8'h00,
    ptr:      8'h00,
    rnw:      1'b0,
    mack:     1'b0,
    sda_low:  1'b0,
    scl_prev: 1'b1,
    sda_prev: 1'b1,
    gain:     `HPGRB_GAIN_RST,
    flt:      `HPGRB_FLT_RST
  };

  hpgrb_pkg::hpgrb_bank_st_t q;
  hpgrb_pkg::hpgrb_bank_st_t d;

  logic       scl;
  logic       sda;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_evt;
  logic       stop_evt;
  logic       wr_en;
  logic       rd_load;
  logic       adr_hit;
  logic       adr_miss;
  logic [7:0] rd_byte;

  // Returns the byte read back at an offset; unknown and test offsets read zero.
  function automatic logic [7:0] read_mux(input logic [7:0] ofs,
                                          input logic [7:0] gain,
                                          input logic [1:0] flt);
    logic [7:0] r;
    r = 8'h00;
    if (ofs == `HPGRB_OFS_GAIN) begin
      r = gain;
    end else if (ofs == `HPGRB_OFS_FLOAT) begin
      r = {6'h00, flt};
    end else if (ofs == `HPGRB_OFS_REV) begin
      r = {4'h0, REVISION};
    end
    return r;
  endfunction

  // Both bus lines pass the three-stage filter before any decoding.
  hpgrb_sync #(.RST_LEVEL(1'b1)) u_scl_sync (
    .clk_in    (CLK_IN),
    .srst_in   (SRST_IN),
    .async_in  (SCL_IN),
    .level_out (scl)
  );

  hpgrb_sync #(.RST_LEVEL(1'b1)) u_sda_sync (
    .clk_in    (CLK_IN),
    .srst_in   (SRST_IN),
    .async_in  (SDA_IN),
    .level_out (sda)
  );

  // Bus events seen on the filtered lines.
  assign scl_rise  = scl & ~q.scl_prev;
  assign scl_fall  = ~scl & q.scl_prev;
  assign start_evt = scl & q.scl_prev & q.sda_prev & ~sda;
  assign stop_evt  = scl & q.scl_prev & ~q.sda_prev & sda;
  assign rd_byte   = read_mux(q.ptr, q.gain, q.flt);

  // Slave sequencing, byte shifting and register updates.
  always_comb begin
    d          = q;
    wr_en      = 1'b0;
    rd_load    = 1'b0;
    adr_hit    = 1'b0;
    adr_miss   = 1'b0;
    d.scl_prev = scl;
    d.sda_prev = sda;
    if (start_evt) begin
      // A start or repeated start always restarts the address phase.
      d.st      = hpgrb_pkg::HPGRB_ADDR;
      d.bitcnt  = 4'h0;
      d.sda_low = 1'b0;
    end else if (stop_evt) begin
      d.st      = hpgrb_pkg::HPGRB_IDLE;
      d.sda_low = 1'b0;
    end else begin
      case (q.st)
        hpgrb_pkg::HPGRB_ADDR, hpgrb_pkg::HPGRB_PTR, hpgrb_pkg::HPGRB_WR: begin
          if (scl_rise && q.bitcnt != `HPGRB_BYTE_BITS) begin
            d.shreg  = {q.shreg[6:0], sda};
            d.bitcnt = 4'(q.bitcnt + 4'h1);
          end else if (scl_fall && q.bitcnt == `HPGRB_BYTE_BITS) begin
            d.bitcnt = 4'h0;
            if (q.st == hpgrb_pkg::HPGRB_ADDR) begin
              if (q.shreg[7:1] == DEV_ADDR) begin
                adr_hit   = 1'b1;
                d.sda_low = 1'b1;
                d.rnw     = q.shreg[0];
                d.st      = hpgrb_pkg::HPGRB_ADDR_ACK;
              end else begin
                adr_miss  = 1'b1;
                d.st      = hpgrb_pkg::HPGRB_IDLE;
              end
            end else begin
              d.sda_low = 1'b1;
              d.st      = hpgrb_pkg::HPGRB_WR_ACK;
              if (q.st == hpgrb_pkg::HPGRB_PTR) begin
                d.ptr = q.shreg;
              end else begin
                wr_en = 1'b1;
                d.ptr = 8'(q.ptr + 8'h01);
              end
            end
          end
        end
        hpgrb_pkg::HPGRB_ADDR_ACK: begin
          if (scl_fall) begin
            if (q.rnw) begin
              rd_load = 1'b1;
            end else begin
              d.sda_low = 1'b0;
              d.st      = hpgrb_pkg::HPGRB_PTR;
            end
          end
        end
        hpgrb_pkg::HPGRB_WR_ACK: begin
          if (scl_fall) begin
            d.sda_low = 1'b0;
            d.st      = hpgrb_pkg::HPGRB_WR;
          end
        end
        hpgrb_pkg::HPGRB_RD: begin
          if (scl_fall) begin
            if (q.bitcnt == `HPGRB_BYTE_BITS) begin
              d.sda_low = 1'b0;
              d.st      = hpgrb_pkg::HPGRB_RD_ACK;
            end else begin
              d.sda_low = ~q.shreg[7];
              d.shreg   = {q.shreg[6:0], 1'b0};
              d.bitcnt  = 4'(q.bitcnt + 4'h1);
            end
          end
        end
        hpgrb_pkg::HPGRB_RD_ACK: begin
          if (scl_rise) begin
            d.mack = ~sda;
          end else if (scl_fall) begin
            if (q.mack) begin
              rd_load = 1'b1;
            end else begin
              d.st = hpgrb_pkg::HPGRB_IDLE;
            end
          end
        end
        default: begin
          d.sda_low = 1'b0;
        end
      endcase
    end
    // Load the next byte to send and drive its first bit at once.
    if (rd_load) begin
      d.sda_low = ~rd_byte[7];
      d.shreg   = {rd_byte[6:0], 1'b0};
      d.bitcnt  = 4'h1;
      d.ptr     = 8'(q.ptr + 8'h01);
      d.st      = hpgrb_pkg::HPGRB_RD;
    end
    // Store a received byte; revision, test and unknown offsets drop it.
    if (wr_en) begin
      if (q.ptr == `HPGRB_OFS_GAIN) begin
        d.gain = q.shreg;
      end else if (q.ptr == `HPGRB_OFS_FLOAT) begin
        d.flt = q.shreg[`HPGRB_BIT_LFLT:`HPGRB_BIT_RFLT];
      end
      // Writes to the revision and test offsets are ignored.
    end
  end

  // All state updates here; reset restores mute on and gain at its lowest.
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      q <= BANK_RST;
    end else begin
      q <= d;
    end
  end

  // Open-drain data line and the amplifier controls.
  assign SDA_OUT                = 1'b0;
  assign SDA_OE_OUT             = q.sda_low;
  assign LEFT_SILENCE_OUT       = q.gain[`HPGRB_BIT_LSIL];
  assign RIGHT_SILENCE_OUT      = q.gain[`HPGRB_BIT_RSIL];
  assign GAIN_CODE_OUT          = q.gain[`HPGRB_GAIN_MSB:`HPGRB_GAIN_LSB];
  assign LEFT_OUTPUT_FLOAT_OUT  = q.flt[`HPGRB_BIT_LFLT];
  assign RIGHT_OUTPUT_FLOAT_OUT = q.flt[`HPGRB_BIT_RFLT];

  // Reset leaves both channels silenced, gain lowest and outputs driven.
  chk_reset_values: assert property (
    @(posedge CLK_IN) disable iff (1'b0)
    SRST_IN |=> (LEFT_SILENCE_OUT && RIGHT_SILENCE_OUT && GAIN_CODE_OUT == 6'h00
                 && !LEFT_OUTPUT_FLOAT_OUT && !RIGHT_OUTPUT_FLOAT_OUT && !SDA_OE_OUT))
    else $error("Reset values of the controls are wrong.");

  // A gain write lands on all three gain outputs one cycle later.
  chk_gain_write: assert property (
    @(posedge CLK_IN) disable iff (SRST_IN)
    (wr_en && q.ptr == `HPGRB_OFS_GAIN) |=>
      (LEFT_SILENCE_OUT == $past(q.shreg[`HPGRB_BIT_LSIL])
       && RIGHT_SILENCE_OUT == $past(q.shreg[`HPGRB_BIT_RSIL])
       && GAIN_CODE_OUT == $past(q.shreg[`HPGRB_GAIN_MSB:`HPGRB_GAIN_LSB])))
    else $error("Gain register write did not reach the outputs.");

  // Silence outputs only move on a completed byte write.
  chk_silence_hold: assert property (
    @(posedge CLK_IN) disable iff (SRST_IN)
    !$stable(LEFT_SILENCE_OUT) || !$stable(RIGHT_SILENCE_OUT) |-> $past(wr_en))
    else $error("Silence output changed without a write.");

  // A float write sets both float outputs from the low two bits.
  chk_float_write: assert property (
    @(posedge CLK_IN) disable iff (SRST_IN)
    (wr_en && q.ptr == `HPGRB_OFS_FLOAT) |=>
      (LEFT_OUTPUT_FLOAT_OUT == $past(q.shreg[`HPGRB_BIT_LFLT])
       && RIGHT_OUTPUT_FLOAT_OUT == $past(q.shreg[`HPGRB_BIT_RFLT])))
    else $error("Float register write did not reach the outputs.");

  // Reading the float register sends a zero top bit, pulling the line.
  chk_float_read: assert property (
    @(posedge CLK_IN) disable iff (SRST_IN)
    (rd_load && q.ptr == `HPGRB_OFS_FLOAT) |=> (SDA_OE_OUT && q.shreg[7:3] == 5'h00))
    else $error("Float register upper bits did not read as zero.");

  // Reading the revision register sends zeros above a fixed code.
  chk_rev_read: assert property (
    @(posedge CLK_IN) disable iff (SRST_IN)
    (rd_load && q.ptr == `HPGRB_OFS_REV) |=> (SDA_OE_OUT && q.shreg == {3'h0, REVISION, 1'b0}))
    else $error("Revision register read returned a wrong byte.");

  // A write at the revision offset leaves every control untouched.
  chk_rev_nowrite: assert property (
    @(posedge CLK_IN) disable iff (SRST_IN)
    (wr_en && q.ptr == `HPGRB_OFS_REV) |=> ($stable(q.gain) && $stable(q.flt)))
    else $error("Revision register write changed a control.");

  // A foreign address releases the line and returns to idle.
  chk_addr_ignore: assert property (
    @(posedge CLK_IN) disable iff (SRST_IN)
    adr_miss |=> (!SDA_OE_OUT && q.st == hpgrb_pkg::HPGRB_IDLE))
    else $error("Foreign bus address was acknowledged.");

  // Our own address is acknowledged on the next cycle.
  chk_addr_ack: assert property (
    @(posedge CLK_IN) disable iff (SRST_IN)
    adr_hit |=> (SDA_OE_OUT && q.st == hpgrb_pkg::HPGRB_ADDR_ACK))
    else $error("Own bus address was not acknowledged.");

  // Each stored byte advances the offset by one.
  chk_write_step: assert property (
    @(posedge CLK_IN) disable iff (SRST_IN)
    wr_en |=> (q.ptr == 8'($past(q.ptr) + 8'h01) && SDA_OE_OUT))
    else $error("Write offset did not advance by one.");

  // Each loaded read byte advances the offset and enters the send phase.
  chk_read_step: assert property (
    @(posedge CLK_IN) disable iff (SRST_IN)
    rd_load |=> (q.ptr == 8'($past(q.ptr) + 8'h01) && q.st == hpgrb_pkg::HPGRB_RD))
    else $error("Read offset did not advance by one.");

  // A stop always frees the line at once.
  chk_stop_idle: assert property (
    @(posedge CLK_IN) disable iff (SRST_IN)
    stop_evt |=> (!SDA_OE_OUT && q.st == hpgrb_pkg::HPGRB_IDLE))
    else $error("Stop did not return the slave to idle.");

  // A master not-acknowledge ends the read without another byte.
  chk_nack_end: assert property (
    @(posedge CLK_IN) disable iff (SRST_IN)
    (q.st == hpgrb_pkg::HPGRB_RD_ACK && scl_fall && !q.mack && !start_evt)
      |=> (q.st == hpgrb_pkg::HPGRB_IDLE && !SDA_OE_OUT))
    else $error("Read continued after a not-acknowledge.");

endmodule

`default_nettype wire

// ---- logic/hpgrb_defines.svh ----
// Constants of the headphone gain register bank: bus address, offsets, fields.
// Assumes inclusion by bare name from every file that decodes the bank.
`ifndef HPGRB_DEFINES_SVH
`define HPGRB_DEFINES_SVH

`define HPGRB_DEV_ADDR   7'h60
`define HPGRB_OFS_GAIN   8'h02
`define HPGRB_OFS_FLOAT  8'h03
`define HPGRB_OFS_REV    8'h04
`define HPGRB_BIT_LSIL   7
`define HPGRB_BIT_RSIL   6
`define HPGRB_GAIN_MSB   5
`define HPGRB_GAIN_LSB   0
`define HPGRB_BIT_LFLT   1
`define HPGRB_BIT_RFLT   0
`define HPGRB_GAIN_RST   8'hc0
`define HPGRB_FLT_RST    2'h0
`define HPGRB_BYTE_BITS  4'h8
`define HPGRB_REV_CODE   4'h5

`endif

// ---- logic/hpgrb_pkg.sv ----
// Types shared by the headphone gain register bank and its pin synchroniser.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package hpgrb_pkg;

  // Serial slave phases.
  typedef enum logic [2:0] {
    HPGRB_IDLE,
    HPGRB_ADDR,
    HPGRB_ADDR_ACK,
    HPGRB_PTR,
    HPGRB_WR_ACK,
    HPGRB_WR,
    HPGRB_RD,
    HPGRB_RD_ACK
  } hpgrb_fsm_t;

  // Whole state of the bank module.
  typedef struct packed {
    hpgrb_fsm_t  st;
    logic [3:0]  bitcnt;
    logic [7:0]  shreg;
    logic [7:0]  ptr;
    logic        rnw;
    logic        mack;
    logic        sda_low;
    logic        scl_prev;
    logic        sda_prev;
    logic [7:0]  gain;
    logic [1:0]  flt;
  } hpgrb_bank_st_t;

  // Whole state of one pin synchroniser.
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } hpgrb_sync_st_t;

endpackage

`default_nettype wire

// ---- logic/hpgrb_sync.sv ----
// Three-stage synchroniser with agreement filter for one bus pin.
// Assumes a pin asynchronous to clk_in and a synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none

module hpgrb_sync #(
  parameter logic RST_LEVEL = 1'b1
) (
  input  wire logic clk_in,
  input  wire logic srst_in,
  input  wire logic async_in,
  output var  logic level_out
);

  hpgrb_pkg::hpgrb_sync_st_t q;
  hpgrb_pkg::hpgrb_sync_st_t d;

  // Shift the pin in; the level only moves once stages two and three agree.
  always_comb begin
    d     = q;
    d.s1  = async_in;
    d.s2  = q.s1;
    d.s3  = q.s2;
    d.lvl = (q.s2 == q.s3) ? q.s3 : q.lvl;
  end

  // Register the state; an idle bus line is high.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      q <= '{s1: RST_LEVEL, s2: RST_LEVEL, s3: RST_LEVEL, lvl: RST_LEVEL};
    end else begin
      q <= d;
    end
  end

  assign level_out = q.lvl;

endmodule

`default_nettype wire

// ---- verif/hpgrb_master.sv ----
// Bus master model that drives the serial clock and data lines of the bank.
// Assumes a free-running clk_in and a pull-up on the data line outside.
`timescale 1ns/1ns
`default_nettype none

module hpgrb_master #(
  parameter int HALF = 20
) (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output var  logic scl_out,
  output var  logic sda_low_out
);
  // The clock starts driven high; the data line starts released, so the pull-up holds it high.
  initial begin
    scl_out     = 1'b1;
    sda_low_out = 1'b0;
  end

  // Waits a number of system clock edges.
  task automatic hold(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // Start or repeated start: data falls while the clock is high.
  task automatic start();
    sda_low_out <= 1'b0;
    hold(HALF);
    scl_out <= 1'b1;
    hold(HALF);
    sda_low_out <= 1'b1;
    hold(HALF);
    scl_out <= 1'b0;
    hold(HALF);
  endtask

  // Stop: data rises while the clock is high, leaving the bus idle.
  task automatic stop();
    sda_low_out <= 1'b1;
    hold(HALF);
    scl_out <= 1'b1;
    hold(HALF);
    sda_low_out <= 1'b0;
    hold(HALF);
  endtask

  // One clock pulse; data is set in the low phase and sampled at the end of high.
  task automatic pulse(input logic b, output logic r);
    sda_low_out <= ~b;
    hold(HALF);
    scl_out <= 1'b1;
    hold(HALF);
    r = sda_in;
    scl_out <= 1'b0;
    hold(HALF);
  endtask

  // Sends a byte MSB first and returns high when the slave pulled the ack low.
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      pulse(d[i], r);
    end
    pulse(1'b1, r);
    ack = ~r;
  endtask

  // Receives a byte MSB first, then acks it unless it is the last one.
  task automatic recv(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      pulse(1'b1, r);
      d[i] = r;
    end
    pulse(last, r);
  endtask
endmodule

`default_nettype wire

// ---- verif/testbench.sv ----
// Self-checking bench for the headphone gain register bank.
// Assumes the bank and the bus master model are compiled before this file.
`timescale 1ns/1ns
`default_nettype none

module testbench;
  localparam logic [6:0] DEV = 7'h60;
  localparam logic [3:0] REV = 4'h9;  // Value is arbitrary.

  logic       clk;
  logic       srst;
  logic       scl;
  logic       sda_low;
  logic       sda_oe;
  logic       sda_out;
  logic       left_sil;
  logic       right_sil;
  logic [5:0] gain_code;
  logic       left_flt;
  logic       right_flt;
  wire  logic sda_wire;
  logic [7:0] gain_pins;
  logic [7:0] flt_pins;
  logic [7:0] rq[$];
  int         n_mismatch;
  int         samples_checked;

  // Open-drain data line and the pins gathered in register layout.
  assign sda_wire  = ~(sda_low | (sda_oe & ~sda_out));
  assign gain_pins = {left_sil, right_sil, gain_code};
  assign flt_pins  = {6'h00, left_flt, right_flt};

  hpgrb_bank #(.REVISION(REV)) dut_u (
    .CLK_IN                 (clk),
    .SRST_IN                (srst),
    .SCL_IN                 (scl),
    .SDA_IN                 (sda_wire),
    .SDA_OUT                (sda_out),
    .SDA_OE_OUT             (sda_oe),
    .LEFT_SILENCE_OUT       (left_sil),
    .RIGHT_SILENCE_OUT      (right_sil),
    .GAIN_CODE_OUT          (gain_code),
    .LEFT_OUTPUT_FLOAT_OUT  (left_flt),
    .RIGHT_OUTPUT_FLOAT_OUT (right_flt)
  );

  hpgrb_master m_u (
    .clk_in      (clk),
    .sda_in      (sda_wire),
    .scl_out     (scl),
    .sda_low_out (sda_low)
  );

  // System clock of 100 ns period.
  always #50 clk = ~clk;

  // Compares one byte and reports a mismatch at once.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("Checks made: %0d, mismatches: %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Addresses a slave, sends an offset and data bytes; ok is high if all acked.
  task automatic wr(input logic [6:0] a, input logic [7:0] b[$], output logic ok);
    logic ack;
    m_u.start();
    m_u.send({a, 1'b0}, ok);
    foreach (b[i]) begin
      m_u.send(b[i], ack);
      ok &= ack;
    end
    m_u.stop();
  endtask

  // Sets the offset, turns round with a repeated start and reads n bytes.
  task automatic rd(input logic [7:0] ofs, input int n);
    logic       a0;
    logic       a1;
    logic       a2;
    logic [7:0] d;
    rq = {};
    m_u.start();
    m_u.send({DEV, 1'b0}, a0);
    m_u.send(ofs, a1);
    m_u.start();
    m_u.send({DEV, 1'b1}, a2);
    for (int i = 0; i < n; i++) begin
      m_u.recv(i == n - 1, d);
      rq.push_back(d);
    end
    m_u.stop();
    chk({7'h00, a0 & a1 & a2}, 8'h01, "read acks");
  endtask

  // Reset values at the pins and through a burst read.
  task automatic t_reset();
    chk(gain_pins, 8'hc0, "gain pins after reset");
    chk(flt_pins, 8'h00, "float pins after reset");
    rd(8'h02, 3);
    chk(rq[0], 8'hc0, "gain reg reset");
    chk(rq[1], 8'h00, "float reg reset");
    chk(rq[2], {4'h0, REV}, "revision reg");
  endtask

  // Burst writes, reserved float bits and gain code extremes.
  task automatic t_write();
    logic ok;
    wr(DEV, '{8'h02, 8'h3f, 8'h03}, ok);
    chk({7'h00, ok}, 8'h01, "burst write acks");
    chk(gain_pins, 8'h3f, "loudest unmuted");
    chk(flt_pins, 8'h03, "both floated");
    wr(DEV, '{8'h03, 8'hfd}, ok);
    rd(8'h03, 1);
    chk(rq[0], 8'h01, "float reg drops 7:2");
    chk(flt_pins, 8'h01, "right floated only");
    wr(DEV, '{8'h02, 8'h80}, ok);
    chk(gain_pins, 8'h80, "left muted quietest");
    wr(DEV, '{8'h02, 8'h55}, ok);
    rd(8'h02, 2);
    chk(rq[0], 8'h55, "gain readback");
    chk(rq[1], 8'h01, "next offset readback");
  endtask

  // Writes aimed at the revision register leave it and the gain register alone.
  // Only the revision code bits are offered; the test bit 5 and the test
  // registers at 5 to 8 are never given a one by this bench.
  task automatic t_rev();
    logic ok;
    wr(DEV, '{8'h04, 8'h06}, ok);
    chk({7'h00, ok}, 8'h01, "revision write acked");
    rd(8'h04, 1);
    chk(rq[0], {4'h0, REV}, "revision unchanged");
    chk(gain_pins, 8'h55, "gain untouched");
    rd(8'h01, 1);
    chk(rq[0], 8'h00, "unmapped offset reads zero");
  endtask

  // Foreign addresses get no ack and change nothing.
  task automatic t_foreign();
    logic       ok;
    logic [6:0] al[2];
    al = '{7'h61, 7'h20};
    foreach (al[i]) begin
      wr(al[i], '{8'h02, 8'h3f}, ok);
      chk({7'h00, ok}, 8'h00, "foreign address acked");
      chk(gain_pins, 8'h55, "foreign write landed");
    end
  endtask

  // Cuts a hang short and counts it as a mismatch.
  initial begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end

  // Main sequence: reset for two clocks, then every scenario in turn.
  initial begin
    clk             = 1'b0;
    srst            = 1'b1;
    n_mismatch      = 0;
    samples_checked = 0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    repeat (10) @(posedge clk);
    t_reset();
    t_write();
    t_rev();
    t_foreign();
    give_verdict();
  end
endmodule

`default_nettype wire
